// [rtl/wdcf_pkg.sv]
/*
 * constants shared by the watchdog control and flag logic.
 * assumes one 20 MHz core clock and an avalon-mm register slave.
 */
//
// Overview of operation
// - power-on sets flag bit 6
// - power-on flag cleared only by software write
// - time-out sets flag bit 3 always
// - watchdog reset sets cause flag bit 2
// - power resets clear cause; external keeps it
// - reset enable low: cause flag untouched
// - reset enable bit 1 allows watchdog reset
// - restart bit 0 clears counter, self-clears
// - expiry raises irq; reset 512 clocks later
// - external reset loads pattern 0x000xx0
// - only power-on clears reset enable
// - protected control writes need timed-access window
// - extended enable bits 7-5 read one
// - extended enable bit 4 gates irq
// - extended priority bit 4 sets irq level
// - clock control top bits: 17- to 26-bit interval
// - unlock 0xaa then 0x55, three machine cycles
package wdcf_pkg;
    // ------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] CLOCK_CONTROL_IDX         = 8'h8e;
    localparam logic [7:0] TIMED_ACCESS_UNLOCK_IDX   = 8'hc7;
    localparam logic [7:0] DOG_CONTROL_IDX           = 8'hd8;
    localparam logic [7:0] EXTENDED_IRQ_ENABLE_IDX   = 8'he8;
    localparam logic [7:0] EXTENDED_IRQ_PRIORITY_IDX = 8'hf8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POWER_ON_FLAG_BIT    = 6;
    localparam int DOG_TIMEOUT_BIT      = 3;
    localparam int DOG_CAUSE_BIT        = 2;
    localparam int DOG_RESET_EN_BIT     = 1;
    localparam int DOG_RESTART_BIT      = 0;
    localparam int DOG_IRQ_ENABLE_BIT   = 4;
    localparam int DOG_IRQ_PRIORITY_BIT = 4;
    localparam int INTERVAL_SEL_LSB     = 6;

    // ------------------------------------------------------------
    // reset values and read masks
    // ------------------------------------------------------------
    localparam logic [7:0] CLOCK_CONTROL_RESET   = 8'h01;
    localparam logic [7:0] EXT_IRQ_ENABLE_RESET  = 8'h00;
    localparam logic [7:0] EXT_IRQ_PRIO_RESET    = 8'h00;
    localparam logic [7:0] EXT_IRQ_ENABLE_ONES   = 8'he0;
    localparam logic [7:0] EXT_IRQ_STORE_MASK    = 8'h1f;
    localparam logic [7:0] DOG_CONTROL_READ_MASK = 8'h4f;

    // ------------------------------------------------------------
    // timed access and watchdog timing
    // ------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'haa;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h55;
    localparam int CLOCKS_PER_MACHINE_CYCLE  = 4;
    localparam int UNLOCK_WINDOW_MC          = 3;
    localparam int UNLOCK_WINDOW_CYC =
        UNLOCK_WINDOW_MC * CLOCKS_PER_MACHINE_CYCLE;
    localparam int DOG_RESET_DELAY_CYC       = 512;
    localparam int DOG_LONG_EXP              = 26;
    localparam int DOG_EXP_STEP              = 3;
    localparam int DOG_COUNT_W               = 26;

    typedef logic [1:0] wdcf_sel_t;
endpackage

// [rtl/wdcf_dog_if.sv]
/*
 * signals between the register side and the watchdog counter.
 * assumes both ends share the core clock.
 */
interface wdcf_dog_if;
    import wdcf_pkg::*;
    logic      restart;
    wdcf_sel_t interval_sel;
    logic      reset_enable;
    logic      expire;
    logic      dog_reset;

    modport ctrl  (output restart, output interval_sel,
                   output reset_enable, input expire, input dog_reset);
    modport timer (input restart, input interval_sel,
                   input reset_enable, output expire, output dog_reset);
endinterface

// [rtl/wdcf_timer.sv]
/*
 * free-running watchdog divider, tap compare and reset delay.
 * assumes restart and settings come from the register side.
 */
module wdcf_timer #(
    parameter int DOG_EXP_MAX = wdcf_pkg::DOG_LONG_EXP
) (
    input wire logic   clk,
    input wire logic   rst_n,
    wdcf_dog_if.timer  dog
);
    import wdcf_pkg::*;

    logic [DOG_COUNT_W-1:0] count_reg;
    logic [9:0]             delay_reg;
    logic                   pending_reg;
    logic                   expire_reg;
    logic                   dog_reset_reg;
    logic [DOG_COUNT_W-1:0] tap_mask;

    // --------------------------------------------------------
    // tap selection
    // --------------------------------------------------------
    // each step down from the longest setting shortens by 2^3
    always_comb begin
        int e;
        e = DOG_EXP_MAX - DOG_EXP_STEP * (3 - int'(dog.interval_sel));
        if (e < 1)
            e = 1;
        tap_mask = DOG_COUNT_W'((64'h1 << e) - 64'h1);
    end

    // --------------------------------------------------------
    // divider
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || dog.restart || dog_reset_reg)
            count_reg <= '0;
        else
            count_reg <= count_reg + 1'b1;
    end

    // expiry when every bit below the tap is set, counted from restart
    always_ff @(posedge clk) begin
        if (!rst_n || dog.restart)
            expire_reg <= 1'b0;
        else
            expire_reg <= (count_reg & tap_mask) == tap_mask;
    end

    // --------------------------------------------------------
    // reset delay after time-out
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || dog.restart || dog_reset_reg) begin
            pending_reg <= 1'b0;
            delay_reg   <= '0;
        end else if (expire_reg && !pending_reg) begin
            pending_reg <= 1'b1;
            delay_reg   <= '0;
        end else if (pending_reg) begin
            if (delay_reg == 10'(DOG_RESET_DELAY_CYC - 1))
                pending_reg <= 1'b0;
            delay_reg <= delay_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            dog_reset_reg <= 1'b0;
        else
            dog_reset_reg <= pending_reg && dog.reset_enable &&
                !dog.restart &&
                delay_reg == 10'(DOG_RESET_DELAY_CYC - 1);
    end

    assign dog.expire    = expire_reg;
    assign dog.dog_reset = dog_reset_reg;
endmodule

// [rtl/wdcf_top.sv]
/*
 * watchdog control, reset-cause flags, irq enable and priority bits
 * behind an avalon-mm slave with waitrequest and a timed-access lock.
 * assumes RST_N is the power-on reset; other reset sources are pins.
 */
module wdcf_top #(
    parameter int DOG_EXP_MAX = wdcf_pkg::DOG_LONG_EXP
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        EXT_RESET_PIN,
    input  wire logic        POWER_DOWN_RESET_PIN,
    input  wire logic        POWER_FAIL_RESET_PIN,
    output logic             DOG_IRQ_REQ,
    output logic             DOG_IRQ_HIGH_PRIO,
    output logic             DOG_RESET_OUT
);
    import wdcf_pkg::*;

    wdcf_dog_if dog ();

    function automatic logic hit(input logic [9:0] addr,
                                 input logic [7:0] idx);
        hit = addr == {idx, 2'b00};
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic       ext_rst;
    logic       pwr_rst;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {POWER_FAIL_RESET_PIN, POWER_DOWN_RESET_PIN,
                             EXT_RESET_PIN};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign ext_rst = pin_sync_reg[0];
    assign pwr_rst = pin_sync_reg[1] | pin_sync_reg[2];

    // dog reset is a one-cycle pulse from the counter block
    logic any_soft_rst;
    assign any_soft_rst = ext_rst | pwr_rst | dog.dog_reset;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait state: accept on the second cycle of each request
    logic wait_reg;
    logic req;
    logic take_wr;
    logic [7:0] wbyte;

    assign req     = AVS_READ | AVS_WRITE;
    assign take_wr = AVS_WRITE && !wait_reg && AVS_BYTEENABLE[0];
    assign wbyte   = AVS_WRITEDATA[7:0];

    always_ff @(posedge CLK) begin
        if (!RST_N)
            wait_reg <= 1'b1;
        else
            wait_reg <= !(req && wait_reg);
    end

    // ------------------------------------------------------------
    // timed access unlock
    // ------------------------------------------------------------
    logic       key_armed_reg;
    logic [3:0] window_reg;
    logic       window_open;

    assign window_open = window_reg != 4'h0;

    always_ff @(posedge CLK) begin
        if (!RST_N || any_soft_rst) begin
            key_armed_reg <= 1'b0;
            window_reg    <= 4'h0;
        end else begin
            if (take_wr)
                key_armed_reg <= hit(AVS_ADDRESS, TIMED_ACCESS_UNLOCK_IDX)
                    && wbyte == UNLOCK_KEY_FIRST;
            if (take_wr && key_armed_reg
                && hit(AVS_ADDRESS, TIMED_ACCESS_UNLOCK_IDX)
                && wbyte == UNLOCK_KEY_SECOND)
                window_reg <= 4'(UNLOCK_WINDOW_CYC);
            else if (window_open)
                window_reg <= window_reg - 4'h1;
        end
    end

    logic wr_dog;
    logic wr_prot;
    assign wr_dog  = take_wr && hit(AVS_ADDRESS, DOG_CONTROL_IDX);
    assign wr_prot = wr_dog && window_open;

    // ------------------------------------------------------------
    // dog control flags
    // ------------------------------------------------------------
    logic por_flag_reg;
    logic timeout_reg;
    logic cause_reg;
    logic reset_en_reg;
    logic restart_reg;

    always_ff @(posedge CLK) begin
        if (!RST_N)
            por_flag_reg <= 1'b1;
        else if (wr_prot)
            por_flag_reg <= wbyte[POWER_ON_FLAG_BIT];
    end

    always_ff @(posedge CLK) begin
        if (!RST_N || any_soft_rst)
            timeout_reg <= 1'b0;
        else if (dog.expire)
            timeout_reg <= 1'b1;
        else if (wr_prot)
            timeout_reg <= wbyte[DOG_TIMEOUT_BIT];
    end

    always_ff @(posedge CLK) begin
        if (!RST_N || pwr_rst)
            cause_reg <= 1'b0;
        else if (dog.dog_reset && reset_en_reg)
            cause_reg <= 1'b1;
        else if (ext_rst)
            cause_reg <= cause_reg;
        else if (wr_dog)
            cause_reg <= wbyte[DOG_CAUSE_BIT];
    end

    always_ff @(posedge CLK) begin
        if (!RST_N)
            reset_en_reg <= 1'b0;
        else if (wr_prot && !any_soft_rst)
            reset_en_reg <= wbyte[DOG_RESET_EN_BIT];
    end

    // restart reads back as one for the single cycle it acts
    always_ff @(posedge CLK) begin
        if (!RST_N || any_soft_rst)
            restart_reg <= 1'b0;
        else
            restart_reg <= wr_prot && wbyte[DOG_RESTART_BIT];
    end

    // ------------------------------------------------------------
    // clock control, irq enable, irq priority
    // ------------------------------------------------------------
    logic [7:0] clk_ctrl_reg;
    logic [7:0] irq_en_reg;
    logic [7:0] irq_prio_reg;

    always_ff @(posedge CLK) begin
        if (!RST_N || any_soft_rst)
            clk_ctrl_reg <= CLOCK_CONTROL_RESET;
        else if (take_wr && hit(AVS_ADDRESS, CLOCK_CONTROL_IDX))
            clk_ctrl_reg <= wbyte;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N || any_soft_rst)
            irq_en_reg <= EXT_IRQ_ENABLE_RESET;
        else if (take_wr && hit(AVS_ADDRESS, EXTENDED_IRQ_ENABLE_IDX))
            irq_en_reg <= wbyte & EXT_IRQ_STORE_MASK;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N || any_soft_rst)
            irq_prio_reg <= EXT_IRQ_PRIO_RESET;
        else if (take_wr && hit(AVS_ADDRESS, EXTENDED_IRQ_PRIORITY_IDX))
            irq_prio_reg <= wbyte & EXT_IRQ_STORE_MASK;
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] dog_ctrl_view;
    logic [7:0] rd_byte;

    always_comb begin
        dog_ctrl_view = 8'h00;
        dog_ctrl_view[POWER_ON_FLAG_BIT] = por_flag_reg;
        dog_ctrl_view[DOG_TIMEOUT_BIT]   = timeout_reg;
        dog_ctrl_view[DOG_CAUSE_BIT]     = cause_reg;
        dog_ctrl_view[DOG_RESET_EN_BIT]  = reset_en_reg;
        dog_ctrl_view[DOG_RESTART_BIT]   = restart_reg;
        dog_ctrl_view = dog_ctrl_view & DOG_CONTROL_READ_MASK;
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit(AVS_ADDRESS, DOG_CONTROL_IDX))
            rd_byte = dog_ctrl_view;
        else if (hit(AVS_ADDRESS, EXTENDED_IRQ_ENABLE_IDX))
            rd_byte = irq_en_reg | EXT_IRQ_ENABLE_ONES;
        else if (hit(AVS_ADDRESS, EXTENDED_IRQ_PRIORITY_IDX))
            rd_byte = irq_prio_reg;
        else if (hit(AVS_ADDRESS, CLOCK_CONTROL_IDX))
            rd_byte = clk_ctrl_reg;
    end

    // loaded while waitrequest is high so data stand at the accept edge
    always_ff @(posedge CLK) begin
        if (!RST_N)
            AVS_READDATA <= 32'h0;
        else if (AVS_READ && wait_reg)
            AVS_READDATA <= {24'h0, rd_byte};
    end

    assign AVS_WAITREQUEST = wait_reg;

    // ------------------------------------------------------------
    // outputs and counter hookup
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            DOG_IRQ_REQ       <= 1'b0;
            DOG_IRQ_HIGH_PRIO <= 1'b0;
            DOG_RESET_OUT     <= 1'b0;
        end else begin
            DOG_IRQ_REQ   <= timeout_reg
                && irq_en_reg[DOG_IRQ_ENABLE_BIT];
            DOG_IRQ_HIGH_PRIO <= irq_prio_reg[DOG_IRQ_PRIORITY_BIT];
            DOG_RESET_OUT <= dog.dog_reset;
        end
    end

    assign dog.restart      = restart_reg;
    assign dog.interval_sel = clk_ctrl_reg[INTERVAL_SEL_LSB +: 2];
    assign dog.reset_enable = reset_en_reg;

    wdcf_timer #(
        .DOG_EXP_MAX (DOG_EXP_MAX)
    ) u_timer (
        .clk   (CLK),
        .rst_n (RST_N),
        .dog   (dog.timer)
    );
endmodule

// [testbench/wdcf_top_props.sv]
/*
 * port-level checker for the watchdog control and flag block.
 * assumes one avalon request at a time and registered outputs.
 */
module wdcf_top_props #(
    parameter int DOG_EXP_MAX = 26
) (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [9:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        EXT_RESET_PIN,
    input wire logic        POWER_DOWN_RESET_PIN,
    input wire logic        POWER_FAIL_RESET_PIN,
    input wire logic        DOG_IRQ_REQ,
    input wire logic        DOG_IRQ_HIGH_PRIO,
    input wire logic        DOG_RESET_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------
    a_wait_one: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest did not drop after one cycle");
    a_wait_pulse: assert property (
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    // ----------------------------------------------------------
    // reserved bits and irq outputs
    // ----------------------------------------------------------
    a_enable_ones: assert property (
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h3a0
        |-> AVS_READDATA[7:5] == 3'b111)
        else $error("extended enable top bits not one");
    a_prio_reserved: assert property (
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h3e0
        |-> AVS_READDATA[7:5] == 3'b000)
        else $error("extended priority top bits not zero");
    a_ctrl_reserved: assert property (
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h360
        |-> !AVS_READDATA[7] && !AVS_READDATA[5])
        else $error("dog control reserved bits not zero");
    a_prio_set: assert property (
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h3e0
        && AVS_BYTEENABLE[0] && AVS_WRITEDATA[4]
        |-> ##[1:2] DOG_IRQ_HIGH_PRIO)
        else $error("priority output did not follow write");
    a_irq_gate: assert property (
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h3a0
        && AVS_BYTEENABLE[0] && !AVS_WRITEDATA[4]
        |-> ##[1:2] !DOG_IRQ_REQ)
        else $error("irq request not gated off");
    // ----------------------------------------------------------
    // watchdog reset
    // ----------------------------------------------------------
    a_reset_pulse: assert property (
        DOG_RESET_OUT |=> !DOG_RESET_OUT)
        else $error("watchdog reset longer than one cycle");
    a_reset_clears: assert property (
        DOG_RESET_OUT |-> ##[1:5] (!DOG_IRQ_REQ && !DOG_IRQ_HIGH_PRIO))
        else $error("irq outputs kept after watchdog reset");
    a_reset_quiet: assert property (
        $rose(RST_N) |-> (!DOG_RESET_OUT && !DOG_IRQ_REQ) [*4])
        else $error("activity right after power-on");
endmodule

bind wdcf_top wdcf_top_props #(.DOG_EXP_MAX(DOG_EXP_MAX)) props_u (
    .CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXT_RESET_PIN(EXT_RESET_PIN),
    .POWER_DOWN_RESET_PIN(POWER_DOWN_RESET_PIN),
    .POWER_FAIL_RESET_PIN(POWER_FAIL_RESET_PIN),
    .DOG_IRQ_REQ(DOG_IRQ_REQ), .DOG_IRQ_HIGH_PRIO(DOG_IRQ_HIGH_PRIO),
    .DOG_RESET_OUT(DOG_RESET_OUT));

// [testbench/wdcf_top_tb.sv]
/*
 * register-level bench for the watchdog control and flag block.
 * assumes a small divider exponent so one interval is 1024 clocks.
 */
module wdcf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdcf_pkg::*;
    localparam int         EXP   = 10;
    localparam logic [9:0] A_CK  = {CLOCK_CONTROL_IDX, 2'b00};
    localparam logic [9:0] A_TA  = {TIMED_ACCESS_UNLOCK_IDX, 2'b00};
    localparam logic [9:0] A_DOG = {DOG_CONTROL_IDX, 2'b00};
    localparam logic [9:0] A_EIE = {EXTENDED_IRQ_ENABLE_IDX, 2'b00};
    localparam logic [9:0] A_EIP = {EXTENDED_IRQ_PRIORITY_IDX, 2'b00};
    logic        CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic        EXT_RESET_PIN, POWER_DOWN_RESET_PIN, POWER_FAIL_RESET_PIN;
    logic        DOG_IRQ_REQ, DOG_IRQ_HIGH_PRIO, DOG_RESET_OUT;
    logic [9:0]  AVS_ADDRESS;
    logic [3:0]  AVS_BYTEENABLE;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [7:0]  q;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          n, m;

    wdcf_top #(.DOG_EXP_MAX(EXP)) dut_u (
        .CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .EXT_RESET_PIN(EXT_RESET_PIN),
        .POWER_DOWN_RESET_PIN(POWER_DOWN_RESET_PIN),
        .POWER_FAIL_RESET_PIN(POWER_FAIL_RESET_PIN),
        .DOG_IRQ_REQ(DOG_IRQ_REQ), .DOG_IRQ_HIGH_PRIO(DOG_IRQ_HIGH_PRIO),
        .DOG_RESET_OUT(DOG_RESET_OUT));

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [7:0] d, output logic [7:0] r);
        int k;
        @(posedge CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE     <= w;
        AVS_READ      <= !w;
        for (k = 0; k < 50; k++) begin
            @(posedge CLK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        r = AVS_READDATA[7:0];
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
        if (k == 50) begin
            fail_count++;
            final_report();
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] msk,
                      input logic [7:0] exp);
        xfer(1'b0, a, 8'h00, q);
        chk(q & msk, exp);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, q);
    endtask

    task automatic unlock();
        wr(A_TA, UNLOCK_KEY_FIRST);
        wr(A_TA, UNLOCK_KEY_SECOND);
    endtask

    // which: 0 waits for the irq request, 1 for the watchdog reset
    task automatic wait_out(input logic which, input int lim,
                            output int c);
        for (c = 0; c < lim; c++) begin
            @(posedge CLK);
            if ((which ? DOG_RESET_OUT : DOG_IRQ_REQ) === 1'b1) break;
        end
        if (c == lim) begin
            fail_count++;
            final_report();
        end
    endtask

    task automatic quiet(input int cyc);
        int p;
        p = 0;
        repeat (cyc) begin
            @(posedge CLK);
            if (DOG_RESET_OUT !== 1'b0) p++;
        end
        chk(8'(p), 8'h00);
    endtask

    // held for 8 clocks, the shortest valid external reset
    task automatic pin(input int k);
        @(posedge CLK);
        {POWER_FAIL_RESET_PIN, POWER_DOWN_RESET_PIN, EXT_RESET_PIN}
            <= 3'(3'b001 << k);
        repeat (8) @(posedge CLK);
        {POWER_FAIL_RESET_PIN, POWER_DOWN_RESET_PIN, EXT_RESET_PIN}
            <= 3'b000;
        repeat (6) @(posedge CLK);
    endtask
    // ----------------------------------------------------------
    // main sequence; bit 3 is masked while the short tap runs
    // ----------------------------------------------------------
    initial begin
        RST_N = 1'b0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_ADDRESS = 10'h000;
        AVS_WRITEDATA = 32'h0;
        AVS_BYTEENABLE = 4'h1;
        {POWER_FAIL_RESET_PIN, POWER_DOWN_RESET_PIN, EXT_RESET_PIN} = 3'b000;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        rd(A_DOG, 8'h47, 8'h40);
        rd(A_EIE, 8'hff, 8'he0);
        rd(A_EIP, 8'hff, 8'h00);
        rd(A_CK, 8'hff, CLOCK_CONTROL_RESET);
        rd(10'h004, 8'hff, 8'h00);
        wr(A_DOG, 8'h00);
        rd(A_DOG, 8'h47, 8'h40);
        unlock();
        wr(A_DOG, 8'h41);
        wr(A_CK, 8'hc1);
        rd(A_CK, 8'hff, 8'hc1);
        unlock();
        // restart again: the short tap may have left a reset pending
        wr(A_DOG, 8'h43);
        rd(A_DOG, 8'hff, 8'h42);
        wr(A_EIE, 8'h10);
        rd(A_EIE, 8'hff, 8'hf0);
        wr(A_EIP, 8'hf0);
        rd(A_EIP, 8'hff, 8'h10);
        // a write with the low byte lane off must leave the register alone
        AVS_BYTEENABLE <= 4'h0;
        wr(A_EIP, 8'h00);
        AVS_BYTEENABLE <= 4'h1;
        rd(A_EIP, 8'hff, 8'h10);
        chk({7'h0, DOG_IRQ_HIGH_PRIO}, 8'h01);
        chk({7'h0, DOG_IRQ_REQ}, 8'h00);
        wait_out(1'b0, 1200, n);
        wait_out(1'b1, 600, m);
        chk({7'h0, m >= 508 && m <= 518}, 8'h01);
        rd(A_DOG, 8'h47, 8'h46);
        rd(A_EIE, 8'hff, 8'he0);
        wr(A_CK, 8'hc1);
        unlock();
        wr(A_DOG, 8'h47);
        wr(A_EIE, 8'h10);
        wait_out(1'b0, 1200, n);
        unlock();
        wr(A_DOG, 8'h47);
        quiet(600);
        unlock();
        wr(A_DOG, 8'h44);
        quiet(1700);
        rd(A_DOG, 8'hff, 8'h4c);
        wr(A_EIE, 8'h00);
        repeat (3) @(posedge CLK);
        chk({7'h0, DOG_IRQ_REQ}, 8'h00);
        pin(0);
        rd(A_DOG, 8'h47, 8'h44);
        for (n = 1; n < 3; n++) begin
            wr(A_DOG, 8'h04);
            pin(n);
            rd(A_DOG, 8'h47, 8'h40);
        end
        unlock();
        // restart with the enable so the short tap cannot fire mid-read
        wr(A_DOG, 8'h03);
        rd(A_DOG, 8'h47, 8'h02);
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        rd(A_DOG, 8'h47, 8'h40);
        final_report();
    end
endmodule
